/* shared/dtc_defines.vh */
// constants for the dual timer/counter block
// Notes on behaviour
// R1: mode 2 runs low byte 8-bit; overflow sets flag, reloads low from high.
// R2: high byte writes in auto-reload mode take effect at the next reload.
// R3: overflow flag set on every overflow, cleared on interrupt vector acknowledge.
// R4: unit 0 mode 3 low byte is 8-bit counter with unit 0 controls.
// R5: unit 0 mode 3 high byte counts divided clock, runs on unit 1 run bit.
// R6: unit 1 in mode 3 halts and holds its count.
// R7: unit 1 uses mode bits 7:4 and control bits 7, 6, 3, 2.
// R8: gate clear means run bit enables; gate set also needs interrupt pin high.
// R9: count roll from all ones to zeros sets flag and requests interrupt.
// R10: mode 0 is 13-bit: 5-bit prescaler in low byte feeds high byte.
// R11: mode 1 cascades low and high bytes into one 16-bit counter.
// R12: timer interrupt needs its own enable and the global enable set.
// R13: control bits 7..0: ovf1, run1, ovf0, run0, xflag1, xtype1, xflag0, xtype0.
// R14: run bit 6 or 4 clear stops its unit, set starts it.
// R15: external flag set on detection; edge mode flag cleared by acknowledge.
// R16: external type bit clear is low level, set is falling edge.
// R17: control register is all zeros after reset.
// R18: mode bits 7..0: unit1_pin_gating, source1, mode1 pair, unit0_pin_gating, source0, mode0 pair.
// R19: software should stop a unit before changing its mode.
// R20: timer operation increments once per 6 clock periods.
// R21: count pin sampled each peripheral cycle; high then low advances count.
// R22: source select clear picks divided clock, set picks count pin falls.
// R23: mode codes 00 13-bit, 01 16-bit, 10 auto-reload, 11 mode 3.
// R24: one request per timer and external interrupt, each with an acknowledge.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define DTC_IDX_CTRL  8'h88
`define DTC_IDX_MODE  8'h89
`define DTC_IDX_U0LO  8'h8A
`define DTC_IDX_U1LO  8'h8B
`define DTC_IDX_U0HI  8'h8C
`define DTC_IDX_U1HI  8'h8D
`define DTC_IDX_IEN   8'hA8

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define DTC_C_OVF1  7
`define DTC_C_RUN1  6
`define DTC_C_OVF0  5
`define DTC_C_RUN0  4
`define DTC_C_XF1   3
`define DTC_C_XT1   2
`define DTC_C_XF0   1
`define DTC_C_XT0   0

// ------------------------------------------------------------
// mode register fields, unit 1 at +4
// ------------------------------------------------------------
`define DTC_M_GATE  3
`define DTC_M_SRC   2
`define DTC_M_HI    1
`define DTC_M_LO    0
`define DTC_M_U1    4

// ------------------------------------------------------------
// interrupt enable fields
// ------------------------------------------------------------
`define DTC_E_ALL   7
`define DTC_E_T1    3
`define DTC_E_X1    2
`define DTC_E_T0    1
`define DTC_E_X0    0

// ------------------------------------------------------------
// modes, reset values, timing
// ------------------------------------------------------------
`define DTC_MODE13  2'h0
`define DTC_MODE16  2'h1
`define DTC_MODEAR  2'h2
`define DTC_MODE3   2'h3
`define DTC_RST8    8'h00
`define DTC_PER_DIV 6
`define DTC_DIV_W   3

`endif

/* src/dtc_count_unit.v */
// next-count logic for one timer/counter unit
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_count_unit #(
  parameter HALT_IN_MODE3 = 0
) (
  input  wire [1:0] mode_in,
  input  wire [7:0] lo_in,
  input  wire [7:0] hi_in,
  input  wire       inc_lo_in,
  input  wire       inc_hi_in,
  output reg  [7:0] nxt_lo_out,
  output reg  [7:0] nxt_hi_out,
  output reg        ovf_lo_out,
  output reg        ovf_hi_out
);

  always @* begin
    nxt_lo_out = lo_in;
    nxt_hi_out = hi_in;
    ovf_lo_out = 1'b0;
    ovf_hi_out = 1'b0;
    case (mode_in)
      `DTC_MODE13: begin
        // upper three low-byte bits are left alone
        if (inc_lo_in) begin // R10
          nxt_lo_out[4:0] = lo_in[4:0] + 5'h01;
          if (lo_in[4:0] == 5'h1F) begin
            nxt_hi_out = hi_in + 8'h01;
            ovf_lo_out = (hi_in == 8'hFF); // R9
          end
        end
      end
      `DTC_MODE16: begin
        if (inc_lo_in) begin // R11
          {nxt_hi_out, nxt_lo_out} = {hi_in, lo_in} + 16'h0001;
          ovf_lo_out = ({hi_in, lo_in} == 16'hFFFF); // R9
        end
      end
      `DTC_MODEAR: begin
        if (inc_lo_in) begin // R1
          if (lo_in == 8'hFF) begin
            nxt_lo_out = hi_in; // R2
            ovf_lo_out = 1'b1;
          end else begin
            nxt_lo_out = lo_in + 8'h01;
          end
        end
      end
      default: begin
        if (HALT_IN_MODE3 == 0) begin
          if (inc_lo_in) begin // R4
            nxt_lo_out = lo_in + 8'h01;
            ovf_lo_out = (lo_in == 8'hFF);
          end
          if (inc_hi_in) begin // R5
            nxt_hi_out = hi_in + 8'h01;
            ovf_hi_out = (hi_in == 8'hFF);
          end
        end
      end
    endcase
  end

endmodule

/* src/dtc_timer_top.v */
// dual 16-bit timer/counter with external interrupt flags, Avalon-MM slave
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_timer_top (
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire [9:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [3:0]  avs_byteenable_in,
  input  wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        unit0_count_pin_in,
  input  wire        unit1_count_pin_in,
  input  wire        ext_irq0_pin_n_in,
  input  wire        ext_irq1_pin_n_in,
  input  wire        unit0_irq_ack_in,
  input  wire        unit1_irq_ack_in,
  input  wire        ext_irq0_ack_in,
  input  wire        ext_irq1_ack_in,
  output wire        unit0_irq_out,
  output wire        unit1_irq_out,
  output wire        ext_irq0_irq_out,
  output wire        ext_irq1_irq_out
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  mode_ff;
  reg  [7:0]  ien_ff;
  reg  [7:0]  u0_lo_ff;
  reg  [7:0]  u0_hi_ff;
  reg  [7:0]  u1_lo_ff;
  reg  [7:0]  u1_hi_ff;
  reg         acc_ff;
  reg  [31:0] rdata_ff;
  reg  [`DTC_DIV_W-1:0] div_ff;
  reg  [3:0]  pin_s1_ff;
  reg  [3:0]  pin_s2_ff;
  reg  [1:0]  samp_ff;
  reg  [1:0]  xpin_old_ff;

  // only byte lane 0 carries data,
  // upper lanes read as zero and are ignored on write

  // ------------------------------------------------------------
  // pin synchronisers: {irq1, irq0, count1, count0}
  // ------------------------------------------------------------
  wire [3:0] pin_raw;
  assign pin_raw = {ext_irq1_pin_n_in, ext_irq0_pin_n_in,
                    unit1_count_pin_in, unit0_count_pin_in};

  // sync flops reset high so the idle level of each pin
  // is not mistaken for a falling edge right after reset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_s1_ff[gi] <= 1'b1;
          pin_s2_ff[gi] <= 1'b1;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
        end
      end
    end
  endgenerate

  wire [1:0] cnt_pin;
  wire [1:0] xpin;
  assign cnt_pin = pin_s2_ff[1:0];
  assign xpin    = pin_s2_ff[3:2];

  // ------------------------------------------------------------
  // peripheral cycle tick, one clock in six
  // ------------------------------------------------------------
  // one shared divider keeps both units on the same tick;
  // a unit started mid-cycle may see its first tick up to five clocks early
  wire tick;
  assign tick = (div_ff == (`DTC_PER_DIV - 1)); // R20

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff <= {`DTC_DIV_W{1'b0}};
    end else if (tick) begin
      div_ff <= {`DTC_DIV_W{1'b0}};
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // count pin is looked at once per peripheral cycle only
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      samp_ff <= 2'h3;
    end else if (tick) begin
      samp_ff <= cnt_pin; // R21
    end
  end

  wire [1:0] pin_fall;
  assign pin_fall = samp_ff & ~cnt_pin & {2{tick}}; // R21

  // ------------------------------------------------------------
  // run and increment decisions
  // ------------------------------------------------------------
  wire [3:0] m0;
  wire [3:0] m1;
  assign m0 = mode_ff[3:0];
  assign m1 = mode_ff[7:4]; // R7 R18
  wire [1:0] md0;
  wire [1:0] md1;
  assign md0 = {m0[`DTC_M_HI], m0[`DTC_M_LO]}; // R23
  assign md1 = {m1[`DTC_M_HI], m1[`DTC_M_LO]};
  wire u0_split;
  assign u0_split = (md0 == `DTC_MODE3);

  wire run0;
  wire run1_own;
  wire run1;
  assign run0 = ctrl_ff[`DTC_C_RUN0] & (~m0[`DTC_M_GATE] | xpin[0]); // R8 R14
  assign run1_own = ctrl_ff[`DTC_C_RUN1] & (~m1[`DTC_M_GATE] | xpin[1]); // R8 R14
  // with unit 0 split, unit 1 loses its run bit and runs until put in mode 3
  assign run1 = u0_split ? 1'b1 : run1_own; // R6


  // gate pins share the interrupt synchronisers,
  // so gating lags the pin by the same two clocks as the flags
  wire src0;
  wire src1;
  assign src0 = m0[`DTC_M_SRC] ? pin_fall[0] : tick; // R22
  assign src1 = m1[`DTC_M_SRC] ? pin_fall[1] : tick; // R22

  wire inc0;
  wire inc1;
  wire inc0_hi;
  assign inc0 = run0 & src0;
  assign inc1 = run1 & src1;
  assign inc0_hi = ctrl_ff[`DTC_C_RUN1] & tick; // R5

  wire [7:0] u0_nlo;
  wire [7:0] u0_nhi;
  wire [7:0] u1_nlo;
  wire [7:0] u1_nhi;
  wire       u0_ovf;
  wire       u0_ovf_hi;
  wire       u1_ovf;

  // ------------------------------------------------------------
  // per-unit next-count logic
  // ------------------------------------------------------------
  // unit 1 has no split mode, its mode 3 is a hold
  dtc_count_unit #(
    .HALT_IN_MODE3 (0)
  ) u_cnt0 (
    .mode_in    (md0),
    .lo_in      (u0_lo_ff),
    .hi_in      (u0_hi_ff),
    .inc_lo_in  (inc0),
    .inc_hi_in  (inc0_hi),
    .nxt_lo_out (u0_nlo),
    .nxt_hi_out (u0_nhi),
    .ovf_lo_out (u0_ovf),
    .ovf_hi_out (u0_ovf_hi)
  );

  dtc_count_unit #(
    .HALT_IN_MODE3 (1)
  ) u_cnt1 (
    .mode_in    (md1),
    .lo_in      (u1_lo_ff),
    .hi_in      (u1_hi_ff),
    .inc_lo_in  (inc1),
    .inc_hi_in  (1'b0),
    .nxt_lo_out (u1_nlo),
    .nxt_hi_out (u1_nhi),
    .ovf_lo_out (u1_ovf),
    .ovf_hi_out ()
  );

  // ------------------------------------------------------------
  // bus slave: one wait state on every access
  // ------------------------------------------------------------
  wire       req;
  wire       wr_go;
  wire [7:0] idx;
  wire [7:0] wbyte;
  assign req   = avs_read_in | avs_write_in;
  assign idx   = avs_address_in[9:2];
  assign wbyte = avs_writedata_in[7:0];
  assign wr_go = avs_write_in & acc_ff & avs_byteenable_in[0];
  assign avs_waitrequest_out = req & ~acc_ff;
  assign avs_readdata_out    = rdata_ff;

  wire wr_ctrl;
  wire wr_mode;
  wire wr_ien;
  wire wr_u0lo;
  wire wr_u0hi;
  wire wr_u1lo;
  wire wr_u1hi;
  assign wr_ctrl = wr_go & (idx == `DTC_IDX_CTRL);
  assign wr_mode = wr_go & (idx == `DTC_IDX_MODE);
  assign wr_ien  = wr_go & (idx == `DTC_IDX_IEN);
  assign wr_u0lo = wr_go & (idx == `DTC_IDX_U0LO);
  assign wr_u0hi = wr_go & (idx == `DTC_IDX_U0HI); // R2
  assign wr_u1lo = wr_go & (idx == `DTC_IDX_U1LO);
  assign wr_u1hi = wr_go & (idx == `DTC_IDX_U1HI); // R2

  // read data is captured in the wait cycle, so it stands
  // at the completing edge whatever the counters do after
  reg [7:0] rd_mux;
  always @* begin
    case (idx)
      `DTC_IDX_CTRL: rd_mux = ctrl_ff;
      `DTC_IDX_MODE: rd_mux = mode_ff;
      `DTC_IDX_IEN:  rd_mux = ien_ff;
      `DTC_IDX_U0LO: rd_mux = u0_lo_ff;
      `DTC_IDX_U0HI: rd_mux = u0_hi_ff;
      `DTC_IDX_U1LO: rd_mux = u1_lo_ff;
      `DTC_IDX_U1HI: rd_mux = u1_hi_ff;
      default:       rd_mux = 8'h00;
    endcase
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      acc_ff <= req & ~acc_ff;
      if (avs_read_in & ~acc_ff) begin
        rdata_ff <= {24'h000000, rd_mux};
      end
    end
  end

  // ------------------------------------------------------------
  // count registers: a software write wins over counting
  // ------------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      u0_lo_ff <= `DTC_RST8;
      u0_hi_ff <= `DTC_RST8;
      u1_lo_ff <= `DTC_RST8;
      u1_hi_ff <= `DTC_RST8;
    end else begin
      u0_lo_ff <= wr_u0lo ? wbyte : u0_nlo;
      u0_hi_ff <= wr_u0hi ? wbyte : u0_nhi;
      u1_lo_ff <= wr_u1lo ? wbyte : u1_nlo; // R6
      u1_hi_ff <= wr_u1hi ? wbyte : u1_nhi;
    end
  end

  // ------------------------------------------------------------
  // flags: hardware set wins over any clear in the same cycle
  // ------------------------------------------------------------
  wire set_ovf0;
  wire set_ovf1;
  assign set_ovf0 = u0_ovf; // R4 R9
  // split unit 0 high byte owns unit 1's flag
  assign set_ovf1 = u0_split ? u0_ovf_hi : u1_ovf; // R5 R9


  // ------------------------------------------------------------
  // external interrupt flags
  // ------------------------------------------------------------
  wire [1:0] xtype;
  wire [1:0] xfall;
  wire [1:0] xset;
  wire [1:0] xack;
  assign xtype = {ctrl_ff[`DTC_C_XT1], ctrl_ff[`DTC_C_XT0]};
  assign xfall = xpin_old_ff & ~xpin;
  assign xset  = (xtype & xfall) | (~xtype & ~xpin); // R15 R16
  assign xack  = {ext_irq1_ack_in, ext_irq0_ack_in};

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      xpin_old_ff <= 2'h3;
    end else begin
      xpin_old_ff <= xpin;
    end
  end

  // limitation: a pin pulse shorter than one clock may be missed
  reg [7:0] nxt_ctrl;
  reg [1:0] nxt_xflag;
  reg [1:0] xflag_now;
  always @* begin
    nxt_ctrl  = wr_ctrl ? wbyte : ctrl_ff;
    xflag_now = {nxt_ctrl[`DTC_C_XF1], nxt_ctrl[`DTC_C_XF0]};
    if (unit0_irq_ack_in) begin
      nxt_ctrl[`DTC_C_OVF0] = 1'b0; // R3
    end
    if (unit1_irq_ack_in) begin
      nxt_ctrl[`DTC_C_OVF1] = 1'b0; // R3
    end
    if (set_ovf0) begin
      nxt_ctrl[`DTC_C_OVF0] = 1'b1; // R3
    end
    if (set_ovf1) begin
      nxt_ctrl[`DTC_C_OVF1] = 1'b1; // R3
    end
    // level mode: flag tracks the pin, acknowledge does not clear it
    nxt_xflag = (xflag_now & ~(xack & xtype)) | xset; // R15
    nxt_xflag = nxt_xflag & (xtype | ~xpin); // R16
    nxt_ctrl[`DTC_C_XF1] = nxt_xflag[1];
    nxt_ctrl[`DTC_C_XF0] = nxt_xflag[0];
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `DTC_RST8; // R17
      mode_ff <= `DTC_RST8;
      ien_ff  <= `DTC_RST8;
    end else begin
      ctrl_ff <= nxt_ctrl; // R13
      if (wr_mode) begin
        mode_ff <= wbyte; // R18
      end
      if (wr_ien) begin
        ien_ff <= wbyte;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt requests
  // ------------------------------------------------------------
  wire all_en;
  assign all_en = ien_ff[`DTC_E_ALL];
  assign unit0_irq_out = ctrl_ff[`DTC_C_OVF0] & ien_ff[`DTC_E_T0] & all_en; // R12 R24
  assign unit1_irq_out = ctrl_ff[`DTC_C_OVF1] & ien_ff[`DTC_E_T1] & all_en; // R12 R24
  assign ext_irq0_irq_out = ctrl_ff[`DTC_C_XF0] & ien_ff[`DTC_E_X0] & all_en; // R24
  assign ext_irq1_irq_out = ctrl_ff[`DTC_C_XF1] & ien_ff[`DTC_E_X1] & all_en; // R24
  // requests are levels; timer and edge-mode requests drop on an acknowledge or a control write clearing the flag, level-mode ones follow the pin


endmodule

/* sim/dtc_timer_properties.sv */
// port-level checks for the dual timer block
`timescale 1ns/10ps
module dtc_timer_chk (
  input wire        sys_clk_in,
  input wire        rst_in,
  input wire [9:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [3:0]  avs_byteenable_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        unit0_irq_ack_in,
  input wire        unit1_irq_ack_in,
  input wire        unit0_irq_out,
  input wire        unit1_irq_out,
  input wire        ext_irq0_irq_out,
  input wire        ext_irq1_irq_out
);
  reg  [7:0] ien_ff;
  wire [7:0] idx = avs_address_in[9:2];
  wire       req = avs_read_in | avs_write_in;
  wire       hit = (idx >= 8'h88 && idx <= 8'h8D) || idx == 8'hA8;
  wire [3:0] irqs = {ext_irq1_irq_out, ext_irq0_irq_out, unit1_irq_out, unit0_irq_out};
  // enable shadow, so masking is judged from bus traffic alone
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in)
      ien_ff <= 8'h00;
    else if (avs_write_in && !avs_waitrequest_out && idx == 8'hA8 && avs_byteenable_in[0])
      ien_ff <= avs_writedata_in[7:0];
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ----
  // sequences
  // ----
  sequence s_req_new;
    req && !$past(req);
  endsequence
  sequence s_ack0;
    (unit0_irq_ack_in && !avs_write_in)[*2];
  endsequence
  sequence s_ack1;
    (unit1_irq_ack_in && !avs_write_in)[*2];
  endsequence
  a_wait_first: assert property (s_req_new |-> avs_waitrequest_out)
    else $error("request not held off in its first cycle");
  a_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait state");
  a_data_upper: assert property (avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && !hit
    |-> avs_readdata_out == 32'h00000000) else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(rst_in) |-> irqs == 4'h0)
    else $error("interrupt request out of reset");
  a_global_mask: assert property (!ien_ff[7] |-> irqs == 4'h0)
    else $error("request with global enable clear");
  a_unit_mask: assert property ((!unit0_irq_out || ien_ff[1]) && (!unit1_irq_out || ien_ff[3])
    && (!ext_irq0_irq_out || ien_ff[0]) && (!ext_irq1_irq_out || ien_ff[2]))
    else $error("request with own enable clear");
  a_ack0_clear: assert property (s_ack0 |-> !unit0_irq_out or ##1 !unit0_irq_out)
    else $error("unit0 flag not cleared by acknowledge");
  a_ack1_clear: assert property (s_ack1 |-> !unit1_irq_out or ##1 !unit1_irq_out)
    else $error("unit1 flag not cleared by acknowledge");
endmodule

bind dtc_timer_top dtc_timer_chk dtc_timer_chk_inst (.sys_clk_in, .rst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
  .avs_waitrequest_out, .unit0_irq_ack_in, .unit1_irq_ack_in, .unit0_irq_out,
  .unit1_irq_out, .ext_irq0_irq_out, .ext_irq1_irq_out);

/* sim/tb.sv */
// self-checking bench for the dual timer block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [9:0]  avs_address_in = 10'h000;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [3:0]  avs_byteenable_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  wire  [31:0] avs_readdata_out;
  wire         avs_waitrequest_out;
  logic        unit0_count_pin_in = 1'b1, unit1_count_pin_in = 1'b1;
  logic        ext_irq0_pin_n_in = 1'b1, ext_irq1_pin_n_in = 1'b1;
  logic        unit0_irq_ack_in = 1'b0, unit1_irq_ack_in = 1'b0;
  logic        ext_irq0_ack_in = 1'b0, ext_irq1_ack_in = 1'b0;
  wire         unit0_irq_out, unit1_irq_out, ext_irq0_irq_out, ext_irq1_irq_out;
  wire  [3:0]  irq_v = {ext_irq1_irq_out, ext_irq0_irq_out, unit1_irq_out, unit0_irq_out};
  int          fails = 0, num_checks = 0, cyc = 0, t1, t2, t3;
  logic [7:0]  rv;

  dtc_timer_top dtc_timer_top_inst (.sys_clk_in, .rst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .unit0_count_pin_in, .unit1_count_pin_in, .ext_irq0_pin_n_in,
    .ext_irq1_pin_n_in, .unit0_irq_ack_in, .unit1_irq_ack_in, .ext_irq0_ack_in,
    .ext_irq1_ack_in, .unit0_irq_out, .unit1_irq_out, .ext_irq0_irq_out, .ext_irq1_irq_out);

  // ----
  // clock, timeout, bus helpers
  // ----
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      final_report;
    end
  end
  task automatic final_report;
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input bit w, input [7:0] i, input [7:0] d, input [3:0] be);
    @(posedge sys_clk_in);
    avs_address_in <= {i, 2'h0};
    avs_writedata_in <= {24'h000000, d};
    avs_byteenable_in <= be;
    if (w) avs_write_in <= 1'b1;
    else avs_read_in <= 1'b1;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    rv = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wr(input [7:0] i, input [7:0] d);
    bus(1'b1, i, d, 4'h1);
  endtask
  task automatic rdc(input [7:0] i, input [7:0] e);
    bus(1'b0, i, 8'h00, 4'hF);
    `CHK("register", e, rv)
  endtask
  // bounded by the global timeout
  task automatic wt(input int u, output int t);
    while (irq_v[u] !== 1'b1) @(posedge sys_clk_in);
    t = cyc;
  endtask
  task automatic ack(input int u);
    @(posedge sys_clk_in);
    unit0_irq_ack_in <= (u == 0);
    unit1_irq_ack_in <= (u == 1);
    ext_irq0_ack_in <= (u == 2);
    repeat (2) @(posedge sys_clk_in);
    {unit0_irq_ack_in, unit1_irq_ack_in, ext_irq0_ack_in} <= 3'h0;
    @(posedge sys_clk_in);
  endtask
  task automatic pulse;
    unit1_count_pin_in <= 1'b1;
    repeat (14) @(posedge sys_clk_in);
    unit1_count_pin_in <= 1'b0;
    repeat (14) @(posedge sys_clk_in);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    for (int i = 0; i < 7; i++) rdc(i == 6 ? 8'hA8 : 8'h88 + i[7:0], 8'h00);
    wr(8'h89, 8'hA5);
    bus(1'b1, 8'h89, 8'h5A, 4'h0);
    rdc(8'h89, 8'hA5);
    wr(8'h90, 8'hFF);
    rdc(8'h90, 8'h00);
  endtask
  task automatic t_mode2;
    wr(8'hA8, 8'h82);
    wr(8'h8C, 8'h80);
    wr(8'h8A, 8'hFE);
    wr(8'h89, 8'h02);
    wr(8'h88, 8'h10);
    wt(0, t1);
    ack(0);
    `CHK("irq0", 1'b0, unit0_irq_out)
    wr(8'h8C, 8'hF0);
    wt(0, t2);
    `CHK("reload gap", 768, t2 - t1)
    ack(0);
    wt(0, t3);
    `CHK("new reload gap", 96, t3 - t2)
    wr(8'h88, 8'h20);
    rdc(8'h8C, 8'hF0);
    wr(8'hA8, 8'h02);
    @(posedge sys_clk_in);
    `CHK("masked irq0", 1'b0, unit0_irq_out)
    rdc(8'h88, 8'h20);
    wr(8'h88, 8'h00);
  endtask
  // unit1 counts pin falls, gated by its interrupt pin
  task automatic t_gate;
    wr(8'hA8, 8'h88);
    wr(8'h8B, 8'hFE);
    wr(8'h8D, 8'hFF);
    wr(8'h89, 8'hD0);
    ext_irq1_pin_n_in <= 1'b0;
    wr(8'h88, 8'h40);
    pulse;
    pulse;
    rdc(8'h8B, 8'hFE);
    `CHK("ext1 masked", 1'b0, ext_irq1_irq_out)
    ext_irq1_pin_n_in <= 1'b1;
    pulse;
    rdc(8'h8B, 8'hFF);
    pulse;
    rdc(8'h8D, 8'h00);
    `CHK("irq1", 1'b1, unit1_irq_out)
    ack(1);
    `CHK("irq1", 1'b0, unit1_irq_out)
    wr(8'h88, 8'h00);
    pulse;
    rdc(8'h8B, 8'h00);
  endtask
  task automatic t_mode0;
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h88, 8'h10);
    repeat (8) @(posedge sys_clk_in);
    wr(8'h88, 8'h00);
    rdc(8'h8C, 8'h01);
    bus(1'b0, 8'h8A, 8'h00, 4'h1);
    `CHK("lo0 top bits", 3'h7, rv[7:5])
  endtask
  task automatic t_mode3;
    wr(8'h89, 8'h33);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h55);
    wr(8'h8C, 8'hFE);
    wr(8'hA8, 8'h8A);
    wr(8'h88, 8'h40);
    wt(1, t1);
    `CHK("irq0", 1'b0, unit0_irq_out)
    wr(8'h88, 8'h00);
    rdc(8'h8B, 8'h55);
    rdc(8'h8A, 8'h00);
  endtask
  task automatic t_ext(input bit fe);
    wr(8'h88, {7'h00, fe});
    wr(8'hA8, 8'h81);
    ext_irq0_pin_n_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rdc(8'h88, {6'h00, 1'b1, fe});
    ext_irq0_pin_n_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    `CHK("ext0 after pin high", fe, ext_irq0_irq_out)
    ack(2);
    `CHK("ext0 after ack", 1'b0, ext_irq0_irq_out)
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_mode2;
    t_gate;
    t_mode0;
    t_mode3;
    t_ext(1'b1);
    t_ext(1'b0);
    final_report;
  end
endmodule
